// File: hw/sfr_defines.svh
// constants of the serial memory slave: opcodes, status layout, register map
// assumes it is included by bare name from files that need these values
`ifndef SFR_DEFINES_SVH
`define SFR_DEFINES_SVH

// array geometry and write fifo depth
`define SFR_ADDR_W 14
`define SFR_MEM_DEPTH 16384
`define SFR_DATA_W 8
`define SFR_FIFO_DEPTH 32

// serial opcodes
`define SFR_OP_WREN 8'h06
`define SFR_OP_WRDI 8'h04
`define SFR_OP_RDSR 8'h05
`define SFR_OP_WRSR 8'h01
`define SFR_OP_READ 8'h03
`define SFR_OP_FSTRD 8'h0b
`define SFR_OP_WRITE 8'h02
`define SFR_OP_RDID 8'h9f

// status byte field positions
`define SFR_ST_PPE_BIT 7
`define SFR_ST_BP_HI 3
`define SFR_ST_BP_LO 2
`define SFR_ST_WEL_BIT 1

// apb register byte offsets
`define SFR_REG_CTRL 8'h00
`define SFR_REG_STAT 8'h04
`define SFR_REG_ID 8'h08
`define SFR_REG_WCNT 8'h0c

// ctrl register fields and reset values
`define SFR_CTRL_EN_BIT 0
`define SFR_CTRL_HOLD_BIT 1
`define SFR_CTRL_EN_RST 1'b1
`define SFR_CTRL_HOLD_RST 1'b0

// arbitrary identification value
`define SFR_ID_DEFAULT 32'h5a3c_0101

`endif

// File: hw/sfr_pkg.sv
// types shared by the serial memory slave files
// assumes sfr_defines.svh is on the include path
`include "sfr_defines.svh"

package sfr_pkg;

  typedef enum logic [9:0]
  {
    ST_STANDBY = 10'h001,
    ST_CMD = 10'h002,
    ST_ADDR = 10'h004,
    ST_DUMMY = 10'h008,
    ST_WRDATA = 10'h010,
    ST_RDDATA = 10'h020,
    ST_SROUT = 10'h040,
    ST_SRIN = 10'h080,
    ST_IDOUT = 10'h100,
    ST_IGNORE = 10'h200
  } sfr_state_t;

  typedef struct packed
  {
    logic [`SFR_ADDR_W-1:0] addr;
    logic [`SFR_DATA_W-1:0] data;
  } sfr_wr_t;

  typedef struct packed
  {
    logic select_n;
    logic serial_clock;
    logic serial_in;
    logic pause_n;
    logic write_protect_n;
  } sfr_pins_t;

  typedef struct packed
  {
    logic protect_pin_enable;
    logic [1:0] block_protect;
    logic write_enable;
  } sfr_status_t;

  typedef struct packed
  {
    sfr_pins_t pins_meta;
    sfr_pins_t pins_sync;
    logic sck_prev;
    logic cs_prev;
    sfr_state_t st;
    logic [7:0] opcode;
    logic mode3;
    logic [6:0] in_shift;
    logic [2:0] in_cnt;
    logic byte_cnt;
    logic [`SFR_ADDR_W-1:0] addr;
    sfr_status_t status;
    logic [7:0] out_byte;
    logic [6:0] out_shift;
    logic [2:0] out_cnt;
    logic fetch;
    logic driving;
    logic so;
    logic so_oe;
    logic [1:0] id_idx;
    sfr_wr_t pend;
    logic pend_valid;
    logic enable;
    logic drain_hold;
    logic [15:0] wcount;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sfr_top_state_t;

endpackage

// File: hw/sfr_fifo.sv
// fifo carrying write requests from the serial side to the array
// assumes one clock, drain side may stall at any time
`timescale 1ns/100ps
`default_nettype none

module sfr_fifo #(
  parameter int W = 22,
  parameter int D = 32
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);

  typedef struct packed
  {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t r_reg;
  fifo_state_t r_next;
  logic push;
  logic pop;

  assign in_ready = (r_reg.count != (AW + 1)'(D));
  assign out_valid = (r_reg.count != '0);
  assign out_data = r_reg.mem[r_reg.rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb
  begin
    r_next = r_reg;
    if (push)
    begin
      r_next.mem[r_reg.wr_ptr] = in_data;
      r_next.wr_ptr = (r_reg.wr_ptr == AW'(D - 1)) ? '0 : r_reg.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      r_next.rd_ptr = (r_reg.rd_ptr == AW'(D - 1)) ? '0 : r_reg.rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10: r_next.count = r_reg.count + 1'b1;
      2'b01: r_next.count = r_reg.count - 1'b1;
      default: r_next.count = r_reg.count;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end
endmodule

`default_nettype wire

// File: hw/sfr_mem.sv
// 16k by 8 storage array, one port, registered read data
// assumes read and write are never asked in the same cycle
`timescale 1ns/100ps
`default_nettype none
`include "sfr_defines.svh"

module sfr_mem
  import sfr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire sfr_pkg::sfr_wr_t wr,
  input wire logic rd_en,
  input wire logic [`SFR_ADDR_W-1:0] rd_addr,
  output logic [`SFR_DATA_W-1:0] rd_data
);
  logic [`SFR_DATA_W-1:0] mem_reg [0:`SFR_MEM_DEPTH-1];
  logic [`SFR_DATA_W-1:0] rd_data_reg;

  assign rd_data = rd_data_reg;

  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem_reg[wr.addr] <= wr.data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data_reg <= '0;
    else if (rd_en)
      rd_data_reg <= mem_reg[rd_addr];
  end
endmodule

`default_nettype wire

// File: hw/sfr_top.sv
// serial memory slave: oversampled four-wire link, status, protection, apb view
// assumes pclk well above the serial clock; pins arrive unsynchronised
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "sfr_defines.svh"

// Summary of operation
// - inputs taken on serial clock rising edge, output changes on falling edge
// - any clock rate well below pclk, clock may stop anywhere without losing state
// - deselected: standby, inputs ignored, output released
// - output driven only for read data, status and identification bytes, released while paused
// - protect pin low with pin enable set blocks status writes
// - pause low freezes operation, clock and select edges ignored
// - each data byte committed once complete, never busy; with the write fifo full the pending byte is overwritten by the next one
// - clock modes 0 and 3 only
// - storage is 16384 bytes
// - software protection of upper quarter, upper half or all
// - write disable command clears write permission
// - fixed read-only identification value
// - two address bytes, low 14 bits used
// - all bytes shifted most significant bit first
// - unknown opcode: ignore rest, output released until next select
// - select falling edge samples clock level to pick mode
module sfr_top #(
  parameter logic [31:0] ID_VALUE = `SFR_ID_DEFAULT
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic select_n,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic pause_n,
  input wire logic write_protect_n,
  output logic serial_out,
  output logic serial_out_oe
);
  import sfr_pkg::*;

  sfr_top_state_t r_reg;
  sfr_top_state_t r_next;
  sfr_pins_t pins_in;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  logic [7:0] in_byte;
  logic [7:0] st_byte;
  logic mem_rd_en;
  logic [`SFR_ADDR_W-1:0] mem_rd_addr;
  logic [`SFR_DATA_W-1:0] mem_rd_data;
  logic fifo_in_ready;
  sfr_wr_t fifo_out;
  logic fifo_out_valid;
  logic drain;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `SFR_REG_CTRL) || (a == `SFR_REG_STAT) ||
      (a == `SFR_REG_ID) || (a == `SFR_REG_WCNT);
  endfunction

  function automatic logic [7:0] status_byte(input sfr_status_t s);
    status_byte = '0;
    status_byte[`SFR_ST_PPE_BIT] = s.protect_pin_enable;
    status_byte[`SFR_ST_BP_HI:`SFR_ST_BP_LO] = s.block_protect;
    status_byte[`SFR_ST_WEL_BIT] = s.write_enable;
  endfunction

  function automatic logic blocked(input logic [1:0] bp, input logic [`SFR_ADDR_W-1:0] a);
    case (bp)
      2'b01: blocked = (a[`SFR_ADDR_W-1:`SFR_ADDR_W-2] == 2'b11);
      2'b10: blocked = a[`SFR_ADDR_W-1];
      2'b11: blocked = 1'b1;
      default: blocked = 1'b0;
    endcase
  endfunction

  assign pins_in = '{select_n, serial_clock, serial_in, pause_n, write_protect_n};
  assign sck_rise = r_reg.pins_sync.serial_clock & ~r_reg.sck_prev;
  assign sck_fall = ~r_reg.pins_sync.serial_clock & r_reg.sck_prev;
  assign cs_rise = r_reg.pins_sync.select_n & ~r_reg.cs_prev;
  assign cs_fall = ~r_reg.pins_sync.select_n & r_reg.cs_prev;
  assign in_byte = {r_reg.in_shift, r_reg.pins_sync.serial_in};
  assign st_byte = status_byte(r_reg.status);
  assign drain = ~mem_rd_en & ~r_reg.drain_hold;

  always_comb
  begin
    r_next = r_reg;
    mem_rd_en = 1'b0;
    mem_rd_addr = r_reg.addr;
    r_next.pins_meta = pins_in;
    r_next.pins_sync = r_reg.pins_meta;
    r_next.sck_prev = r_reg.pins_sync.serial_clock;
    r_next.cs_prev = r_reg.pins_sync.select_n;
    r_next.fetch = 1'b0;
    if (r_reg.fetch)
      r_next.out_byte = mem_rd_data;
    if (r_reg.pend_valid & fifo_in_ready)
      r_next.pend_valid = 1'b0;
    // edges seen while paused are dropped, state stays frozen
    if (r_reg.pins_sync.pause_n)
    begin
      if (!r_reg.enable || r_reg.pins_sync.select_n)
      begin
        r_next.st = ST_STANDBY;
        r_next.driving = 1'b0;
      end
      else if (cs_fall)
      begin
        r_next.st = ST_CMD;
        r_next.mode3 = r_reg.pins_sync.serial_clock;
        r_next.in_cnt = '0;
        r_next.out_cnt = '0;
        r_next.byte_cnt = 1'b0;
        r_next.id_idx = '0;
        r_next.driving = 1'b0;
      end
      else if (r_reg.st != ST_STANDBY && r_reg.st != ST_IGNORE)
      begin
        if (sck_rise)
        begin
          r_next.in_shift = in_byte[6:0];
          r_next.in_cnt = r_reg.in_cnt + 3'd1;
          if (r_reg.in_cnt == 3'd7)
          begin
            case (r_reg.st)
              ST_CMD:
              begin
                r_next.opcode = in_byte;
                case (in_byte)
                  `SFR_OP_WREN:
                  begin
                    r_next.status.write_enable = 1'b1;
                    r_next.st = ST_IGNORE;
                  end
                  `SFR_OP_WRDI:
                  begin
                    r_next.status.write_enable = 1'b0;
                    r_next.st = ST_IGNORE;
                  end
                  `SFR_OP_RDSR: r_next.st = ST_SROUT;
                  `SFR_OP_WRSR:
                  begin
                    if (r_reg.status.write_enable &&
                      !(r_reg.status.protect_pin_enable && !r_reg.pins_sync.write_protect_n))
                      r_next.st = ST_SRIN;
                    else
                      r_next.st = ST_IGNORE;
                  end
                  `SFR_OP_READ, `SFR_OP_FSTRD, `SFR_OP_WRITE: r_next.st = ST_ADDR;
                  `SFR_OP_RDID: r_next.st = ST_IDOUT;
                  default: r_next.st = ST_IGNORE;
                endcase
              end
              ST_ADDR:
              begin
                // only the low 14 address bits are kept
                r_next.addr = {r_reg.addr[5:0], in_byte};
                r_next.byte_cnt = 1'b1;
                if (r_reg.byte_cnt)
                begin
                  case (r_reg.opcode)
                    `SFR_OP_WRITE: r_next.st = ST_WRDATA;
                    `SFR_OP_FSTRD: r_next.st = ST_DUMMY;
                    default:
                    begin
                      r_next.st = ST_RDDATA;
                      mem_rd_en = 1'b1;
                      mem_rd_addr = {r_reg.addr[5:0], in_byte};
                      r_next.fetch = 1'b1;
                    end
                  endcase
                end
              end
              ST_DUMMY:
              begin
                r_next.st = ST_RDDATA;
                mem_rd_en = 1'b1;
                r_next.fetch = 1'b1;
              end
              ST_WRDATA:
              begin
                if (r_reg.status.write_enable && !blocked(r_reg.status.block_protect, r_reg.addr))
                begin
                  r_next.pend = '{r_reg.addr, in_byte};
                  r_next.pend_valid = 1'b1;
                end
                r_next.addr = r_reg.addr + 1'b1;
              end
              ST_SRIN:
              begin
                r_next.status.protect_pin_enable = in_byte[`SFR_ST_PPE_BIT];
                r_next.status.block_protect = in_byte[`SFR_ST_BP_HI:`SFR_ST_BP_LO];
                r_next.st = ST_IGNORE;
              end
              default: r_next.st = r_reg.st;
            endcase
          end
        end
        if (sck_fall && (r_reg.st == ST_RDDATA || r_reg.st == ST_SROUT || r_reg.st == ST_IDOUT))
        begin
          r_next.driving = 1'b1;
          r_next.out_cnt = r_reg.out_cnt + 3'd1;
          if (r_reg.out_cnt == 3'd0)
          begin
            case (r_reg.st)
              ST_RDDATA:
              begin
                r_next.so = r_reg.out_byte[7];
                r_next.out_shift = r_reg.out_byte[6:0];
                r_next.addr = r_reg.addr + 1'b1;
                mem_rd_en = 1'b1;
                mem_rd_addr = r_reg.addr + 1'b1;
                r_next.fetch = 1'b1;
              end
              ST_SROUT:
              begin
                r_next.so = st_byte[7];
                r_next.out_shift = st_byte[6:0];
              end
              default:
              begin
                r_next.so = ID_VALUE[{~r_reg.id_idx, 3'd7}];
                r_next.out_shift = ID_VALUE[{~r_reg.id_idx, 3'd0} +: 7];
                r_next.id_idx = r_reg.id_idx + 2'd1;
              end
            endcase
          end
          else
          begin
            r_next.so = r_reg.out_shift[6];
            r_next.out_shift = {r_reg.out_shift[5:0], 1'b0};
          end
        end
      end
    end
    r_next.so_oe = r_next.driving & r_reg.pins_sync.pause_n;
    if (!mem_rd_en && !r_reg.drain_hold && fifo_out_valid)
      r_next.wcount = r_reg.wcount + 16'd1;
    // apb: pready one cycle into the access phase, effect at that edge
    r_next.pready = 1'b0;
    r_next.pslverr = 1'b0;
    if (psel && penable && !r_reg.pready)
    begin
      r_next.pready = 1'b1;
      r_next.pslverr = ~addr_ok(paddr);
      r_next.prdata = '0;
      if (!pwrite)
      begin
        case (paddr)
          `SFR_REG_CTRL:
          begin
            r_next.prdata[`SFR_CTRL_EN_BIT] = r_reg.enable;
            r_next.prdata[`SFR_CTRL_HOLD_BIT] = r_reg.drain_hold;
          end
          `SFR_REG_STAT:
            r_next.prdata = {11'h000, r_reg.pend_valid, r_reg.pins_sync.pause_n,
              r_reg.mode3, r_reg.st, status_byte(r_reg.status)};
          `SFR_REG_ID: r_next.prdata = ID_VALUE;
          `SFR_REG_WCNT: r_next.prdata = {16'h0000, r_reg.wcount};
          default: r_next.prdata = '0;
        endcase
      end
    end
    if (psel && penable && r_reg.pready && pwrite && addr_ok(paddr) &&
      paddr == `SFR_REG_CTRL)
    begin
      r_next.enable = pwdata[`SFR_CTRL_EN_BIT];
      r_next.drain_hold = pwdata[`SFR_CTRL_HOLD_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_reg <= '0;
      r_reg.pins_meta <= 5'h1f;
      r_reg.pins_sync <= 5'h1f;
      r_reg.cs_prev <= 1'b1;
      r_reg.st <= ST_STANDBY;
      r_reg.enable <= `SFR_CTRL_EN_RST;
      r_reg.drain_hold <= `SFR_CTRL_HOLD_RST;
    end
    else
      r_reg <= r_next;
  end

  sfr_fifo #(
    .W($bits(sfr_wr_t)),
    .D(`SFR_FIFO_DEPTH)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_data(r_reg.pend),
    .in_valid(r_reg.pend_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(drain)
  );

  sfr_mem u_mem (
    .clk(pclk),
    .rst_n(presetn),
    .wr_en(drain & fifo_out_valid),
    .wr(fifo_out),
    .rd_en(mem_rd_en),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data)
  );

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign serial_out = r_reg.so;
  assign serial_out_oe = r_reg.so_oe;
endmodule

`default_nettype wire

// File: test/sfr_top_props.sv
// port checks for the serial memory slave
// assumes binding into sfr_top, all in the pclk domain
`timescale 1ns/100ps
`default_nettype none
module sfr_top_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic select_n,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic pause_n,
  input wire logic write_protect_n,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_oe_desel: assert property (select_n [*5] |-> !serial_out_oe)
    else $error("output driven while deselected");
  chk_oe_pause: assert property (!pause_n [*5] |-> !serial_out_oe)
    else $error("output driven while paused");
  chk_oe_select: assert property (serial_out_oe |-> !$past(select_n, 6))
    else $error("output driven without selection");
  chk_so_edge: assert property ((serial_out_oe && serial_clock) [*3]
    |-> $stable(serial_out)) else $error("output moved while clock high");
  chk_ready_lat: assert property (psel && $rose(penable) |=> pready)
    else $error("ready not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  chk_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
    else $error("ready without access");
  cover property (pslverr);
  cover property ($rose(serial_out_oe));
  cover property (!pause_n && !select_n);
endmodule
bind sfr_top sfr_top_props i_sfr_top_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .select_n(select_n), .serial_clock(serial_clock),
  .serial_in(serial_in), .pause_n(pause_n), .write_protect_n(write_protect_n),
  .serial_out(serial_out), .serial_out_oe(serial_out_oe));
`default_nettype wire

// File: test/sfr_mst.sv
// serial bus master model driving the memory slave pins
// assumes pclk of 100 ns; serial clock half period of four pclk
`timescale 1ns/100ps
`default_nettype none
module sfr_mst (
  input wire logic pclk,
  output logic select_n,
  output logic serial_clock,
  output logic serial_in,
  output logic pause_n,
  output logic write_protect_n,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  logic cpol = 1'b0;
  logic so_q = 1'b0;
  initial
  begin
    select_n = 1'b1;
    serial_clock = 1'b0;
    serial_in = 1'b0;
    pause_n = 1'b1;
    write_protect_n = 1'b1;
  end
  always @(posedge pclk)
    if (serial_out_oe)
      so_q <= serial_out;
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic sel(input logic m3);
    cpol = m3;
    serial_clock <= m3;
    tick(2);
    select_n <= 1'b0;
    tick(4);
  endtask
  task automatic desel();
    serial_clock <= cpol;
    tick(2);
    select_n <= 1'b1;
    serial_in <= ~serial_in;
    tick(4);
  endtask
  // one byte; pz is the bit at which the link pauses
  task automatic xb(input logic [7:0] d, input int pz, output logic [7:0] q);
    for (int i = 7; i >= 0; i--)
    begin
      serial_clock <= 1'b0;
      serial_in <= d[i];
      tick(4);
      if (i == pz)
      begin
        pause_n <= 1'b0;
        tick(4);
        repeat (2)
        begin
          serial_clock <= 1'b1;
          tick(4);
          serial_clock <= 1'b0;
          tick(4);
        end
        pause_n <= 1'b1;
        tick(4);
      end
      serial_clock <= 1'b1;
      tick(3);
      q[i] = serial_out_oe ? serial_out : ~so_q;
      tick(1);
    end
  endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
// self-checking bench for the serial memory slave
// assumes the master model drives the pins; registers over apb
`timescale 1ns/100ps
`default_nettype none
`include "sfr_defines.svh"
module testbench;
  import sfr_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d, m, x; logic er;} sfr_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, select_n, serial_clock, serial_in, pause_n, write_protect_n;
  logic serial_out, serial_out_oe, e;
  logic [7:0] b;
  logic [31:0] prdata, q;
  int n_errors = 0, n_tests = 0, cyc = 0, oe_cnt = 0, k;
  sfr_row_t rows[8] = '{
    '{0, 8'h00, 0, 32'h3, 32'h1, 0},
    '{0, 8'h04, 0, 32'hff, 0, 0},
    '{0, 8'h0c, 0, 32'hffff, 0, 0},
    '{0, 8'h08, 0, '1, `SFR_ID_DEFAULT, 0},
    '{1, 8'h08, 32'hdead_beef, 0, 0, 0},
    '{0, 8'h08, 0, '1, `SFR_ID_DEFAULT, 0},
    '{1, 8'h10, 32'h1, 0, 0, 1},
    '{0, 8'h10, 0, '1, 0, 1}};
  sfr_top i_sfr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .select_n(select_n), .serial_clock(serial_clock),
    .serial_in(serial_in), .pause_n(pause_n), .write_protect_n(write_protect_n),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));
  sfr_mst i_sfr_mst (.pclk(pclk), .select_n(select_n), .serial_clock(serial_clock),
    .serial_in(serial_in), .pause_n(pause_n), .write_protect_n(write_protect_n),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));
  initial
    forever #50 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    oe_cnt <= oe_cnt + serial_out_oe;
    if (cyc == 40000)
    begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff pready === 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic sb(input logic [7:0] d, input int pz = -1);
    i_sfr_mst.xb(d, pz, b);
  endtask
  task automatic cmd(input logic [7:0] o, input logic [7:0] d, input logic two);
    i_sfr_mst.sel(1'b0);
    sb(o);
    if (two)
      sb(d);
    i_sfr_mst.desel();
  endtask
  task automatic mem(input logic [7:0] o, input logic [15:0] a, input logic m3,
    input int pz = -1);
    i_sfr_mst.sel(m3);
    sb(o);
    sb(a[15:8]);
    sb(a[7:0]);
    sb(8'h00, pz);
    i_sfr_mst.desel();
  endtask
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("pslverr", rows[i].er, e);
      chk("prdata", rows[i].x, q & rows[i].m);
    end
    $display("done: registers");
    cmd(8'h06, 8'h00, 0);
    k = oe_cnt;
    i_sfr_mst.sel(1'b0);
    sb(8'h02);
    sb(8'hff);
    sb(8'hff);
    sb(8'ha5);
    sb(8'h5a, 3);
    i_sfr_mst.desel();
    chk("oe in write", k, oe_cnt);
    mem(8'h03, 16'h0000, 0, 5);
    chk("wrap byte", 8'h5a, b);
    mem(8'h03, 16'hbfff, 1);
    chk("mode3 read", 8'ha5, b);
    apb(0, 8'h04, 0);
    chk("mode latch", 1, q[18]);
    apb(0, 8'h0c, 0);
    chk("commits", 2, q[15:0]);
    $display("done: write and read");
    cmd(8'h05, 8'h00, 1);
    chk("status wel", 8'h02, b);
    cmd(8'h04, 8'h00, 0);
    cmd(8'h05, 8'h00, 1);
    chk("status cleared", 8'h00, b);
    mem(8'h02, 16'h3fff, 0);
    mem(8'h03, 16'h3fff, 0);
    chk("write refused", 8'ha5, b);
    cmd(8'h06, 8'h00, 0);
    for (int p = 1; p < 4; p++)
    begin
      cmd(8'h01, 8'(p << 2), 1);
      i_sfr_mst.sel(1'b0);
      sb(8'h02);
      sb(8'h20);
      sb(8'h00);
      sb(8'(p));
      i_sfr_mst.desel();
      mem(8'h03, 16'h2000, 0);
      chk("half boundary", 8'h01, b);
    end
    cmd(8'h01, 8'h80, 1);
    i_sfr_mst.write_protect_n <= 1'b0;
    cmd(8'h01, 8'h0c, 1);
    cmd(8'h05, 8'h00, 1);
    chk("pin protect", 8'h82, b);
    i_sfr_mst.write_protect_n <= 1'b1;
    cmd(8'h01, 8'h00, 1);
    cmd(8'h05, 8'h00, 1);
    chk("pin released", 8'h02, b);
    $display("done: protection");
    i_sfr_mst.sel(1'b0);
    sb(8'h9f);
    for (int i = 3; i >= 0; i--)
    begin
      sb(8'h00);
      chk("id byte", `SFR_ID_DEFAULT >> (8 * i) & 32'hff, b);
    end
    i_sfr_mst.desel();
    k = oe_cnt;
    mem(8'hff, 16'h3fff, 0);
    chk("oe unknown op", k, oe_cnt);
    mem(8'h03, 16'h3fff, 0);
    chk("next select", 8'ha5, b);
    $display("done: id and unknown opcode");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(0, 8'h04, 0);
    chk("status after reset", 0, q[7:0]);
    apb(1, 8'h00, 32'h3);
    cmd(8'h06, 8'h00, 0);
    i_sfr_mst.sel(1'b0);
    sb(8'h02);
    sb(8'h01);
    sb(8'h00);
    for (int i = 0; i < 34; i++)
      sb(8'(i + 1));
    i_sfr_mst.desel();
    apb(0, 8'h0c, 0);
    chk("held commits", 0, q[15:0]);
    apb(1, 8'h00, 32'h1);
    repeat (40) @(posedge pclk);
    apb(0, 8'h0c, 0);
    chk("drained commits", 33, q[15:0]);
    mem(8'h03, 16'h0100, 0);
    chk("first queued", 8'h01, b);
    $display("done: fifo and reset");
    summarize();
  end
endmodule
`default_nettype wire
